// ==== common/pfc_defines.vh ====
/*
  Constants for the fault-clear and store command block: command codes, register
  reset values, field positions and timing counts.
  Assumes a 100 MHz mclk; included by bare name from verilog/.
*/
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// Command codes
`define PFC_CMD_OPERATION     8'h01
`define PFC_CMD_TURN_ON_CFG   8'h02
`define PFC_CMD_CLEAR_FAULTS  8'h03
`define PFC_CMD_ALERT_RESP    8'h0c
`define PFC_CMD_WRITE_LOCK    8'h10
`define PFC_CMD_STORE_ALL     8'h15
`define PFC_CMD_STATUS_FIRST  8'h7a
`define PFC_CMD_STATUS_LAST   8'h7d

// Field positions
`define PFC_OP_ON_BIT         7
`define PFC_CFG_PIN_BIT       3
`define PFC_CFG_SW_BIT        2

// Reset values
`define PFC_OPERATION_RST     8'h80
`define PFC_TURN_ON_CFG_RST   8'h1c
`define PFC_WRITE_LOCK_RST    8'h00

// Status registers and persistent store size
`define PFC_NUM_STATUS        4
`define PFC_NUM_OPER          3

// Store timing: 10 ms busy window at 100 MHz
`define PFC_STORE_TIME_MS     10
`define PFC_CLK_MHZ           100
`define PFC_STORE_CYCLES      (`PFC_STORE_TIME_MS * 1000 * `PFC_CLK_MHZ)

`endif

// ==== verilog/pfc_status_reg.v ====
/*
  One status register of fault bits: sticky set from live conditions,
  cleared by a global clear or a write-one-to-clear mask.
  Assumes fault conditions are synchronous to mclk.
*/
`timescale 1ns/1ps
module pfc_status_reg
(
  // Clock and reset
  input  wire       mclk,
  input  wire       resetn,
  // Control
  input  wire       clear_all,
  input  wire       w1c_en,
  input  wire [7:0] w1c_mask,
  input  wire [7:0] cond,
  // State
  output reg  [7:0] bits_q
);

  reg [7:0] bits_d;

  always @*
  begin
    bits_d = bits_q;
    if (clear_all)
    begin
      bits_d = 8'h00;                                       // [RULE_01]
    end
    if (w1c_en)
    begin
      bits_d = bits_d & ~w1c_mask;                          // [RULE_08]
    end
    // Live condition wins over any clear, so a persisting fault comes straight back
    bits_d = bits_d | cond;                                 // [RULE_07]
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bits_q <= 8'h00;                                      // [RULE_03]
    end
    else
    begin
      bits_q <= bits_d;
    end
  end

endmodule // pfc_status_reg

// ==== verilog/pfc_fault_clear.v ====
/*
  Command interpreter for fault clearing, alert response and store-all.
  Takes decoded bus transactions (command byte, data byte, strobes) from a
  byte-level bus engine; inputs are synchronous to mclk. resetn is driven
  low by the bias undervoltage detector.
*/
// Function
// [RULE_01] The clear-faults command clears every set status fault bit at once and releases the alert line.
// [RULE_02] The clear-faults command never re-enables an output that has latched off.
// [RULE_03] Bias undervoltage clears all fault bits and the device restarts in its default state.
// [RULE_04] With pin turn-on configured, faults clear when the enable pin goes low.
// [RULE_05] With software turn-on configured, faults clear when operation bit 7 is written to 0.
// [RULE_06] With both configured, faults clear only once operation bit 7 and the pin are both low.
// [RULE_07] A fault whose condition persists after clearing is set again at once and raises the alert.
// [RULE_08] Non-summary status registers clear bits written as one in a one-byte write.
// [RULE_09] A device holding the alert answers an alert response read with its own address.
// [RULE_10] Competing alert responders arbitrate on the address and the lowest address wins.
// [RULE_11] Store-all copies all operating memory into matching non-volatile user storage.
// [RULE_12] Operating items without a non-volatile location are skipped silently during store-all.
// [RULE_13] The host waits at least 10 ms after store-all before another store or restore.
// [RULE_14] Command codes are decoded and single-byte reads and writes reach the three registers.
`timescale 1ns/1ps
`include "pfc_defines.vh"
module pfc_fault_clear
#(
  parameter        STORE_CYCLES = `PFC_STORE_CYCLES,
  parameter [6:0]  OWN_ADDR     = 7'h40
)
(
  // Clock and reset
  input  wire        mclk,
  input  wire        resetn,
  // Decoded bus transactions
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire        wr_valid,
  input  wire [7:0]  wr_data,
  input  wire        rd_req,
  output reg  [7:0]  rd_data_q,
  output reg         rd_valid_q,
  // Alert response arbitration
  input  wire        ara_req,
  input  wire        ara_bit_strobe,
  input  wire        sda_in,
  output reg         sda_out_q,
  output reg         sda_oe_n_q,
  output reg         ara_won_q,
  // Enable pin and fault conditions
  input  wire        en_pin,
  input  wire [31:0] fault_cond,
  input  wire        latch_off_req,
  // Power stage and alert
  output reg         output_on_q,
  output reg         alert_n_q,
  output reg  [31:0] status_q,
  // Non-volatile store port
  output reg         nvm_wr_q,
  output reg  [1:0]  nvm_idx_q,
  output reg  [7:0]  nvm_data_q,
  output reg         store_busy_q
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_COPY = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;
  localparam [31:0] STORE_CNT = STORE_CYCLES;

  reg  [7:0]  operation_control_q;
  reg  [7:0]  turn_on_source_config_q;
  reg  [7:0]  write_lock_control_q;
  reg         en_pin_q;
  reg         latched_q;
  reg  [2:0]  st_q;
  reg  [31:0] wait_cnt_q;
  reg  [2:0]  ara_cnt_q;
  reg  [7:0]  ara_sh_q;
  reg         ara_lost_q;
  wire [31:0] status_bits;
  wire        cfg_pin;
  wire        cfg_sw;
  wire        op_on;
  wire        sw_off_write;
  wire        pin_fall;
  reg         auto_clear;
  wire        clear_cmd;
  wire        clear_all;
  wire        status_wr;
  wire [1:0]  status_sel;
  wire        locked;

  assign cfg_pin      = turn_on_source_config_q[`PFC_CFG_PIN_BIT];
  assign cfg_sw       = turn_on_source_config_q[`PFC_CFG_SW_BIT];
  assign op_on        = operation_control_q[`PFC_OP_ON_BIT];
  // Write lock: any nonzero value blocks writes to operation and turn-on config; writes to the lock and the status registers still land
  assign locked       = (write_lock_control_q != 8'h00);
  assign sw_off_write = wr_valid && (cmd_code == `PFC_CMD_OPERATION) && !locked
                        && !wr_data[`PFC_OP_ON_BIT];
  assign pin_fall     = en_pin_q && !en_pin;
  assign clear_cmd    = cmd_valid && (cmd_code == `PFC_CMD_CLEAR_FAULTS);   // [RULE_14]
  assign status_wr    = wr_valid && (cmd_code >= `PFC_CMD_STATUS_FIRST)
                        && (cmd_code <= `PFC_CMD_STATUS_LAST);              // [RULE_08]
  assign status_sel   = cmd_code[1:0] - 2'b10;

  always @*
  begin
    auto_clear = 1'b0;
    if (cfg_pin && cfg_sw)
    begin
      // Either event completing the both-low state
      auto_clear = (sw_off_write && !en_pin) ||
                   ((pin_fall) && !op_on && !sw_off_write);                 // [RULE_06]
    end
    else if (cfg_pin)
    begin
      auto_clear = pin_fall;                                                // [RULE_04]
    end
    else if (cfg_sw)
    begin
      auto_clear = sw_off_write;                                            // [RULE_05]
    end
  end

  assign clear_all = clear_cmd || auto_clear;                               // [RULE_01]

  genvar gi;
  generate
    for (gi = 0; gi < `PFC_NUM_STATUS; gi = gi + 1)
    begin : g_stat
      pfc_status_reg u_stat
      (
        .mclk     (mclk),
        .resetn   (resetn),
        .clear_all(clear_all),
        .w1c_en   (status_wr && (status_sel == gi)),
        .w1c_mask (wr_data),
        .cond     (fault_cond[gi*8 +: 8]),
        .bits_q   (status_bits[gi*8 +: 8])
      );
    end
  endgenerate

  // Registers, enable pin, latch-off and alert
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      operation_control_q     <= `PFC_OPERATION_RST;                        // [RULE_03]
      turn_on_source_config_q <= `PFC_TURN_ON_CFG_RST;
      write_lock_control_q    <= `PFC_WRITE_LOCK_RST;
      en_pin_q                <= 1'b0;
      latched_q               <= 1'b0;
      output_on_q             <= 1'b0;
      alert_n_q               <= 1'b1;
      status_q                <= 32'h0000_0000;
      rd_data_q               <= 8'h00;
      rd_valid_q              <= 1'b0;
    end
    else
    begin
      en_pin_q <= en_pin;
      if (wr_valid)
      begin
        if (cmd_code == `PFC_CMD_WRITE_LOCK)
        begin
          write_lock_control_q <= wr_data;                                  // [RULE_14]
        end
        else if (cmd_code == `PFC_CMD_OPERATION && !locked)
        begin
          operation_control_q <= wr_data;                                   // [RULE_14]
        end
        else if (cmd_code == `PFC_CMD_TURN_ON_CFG && !locked)
        begin
          turn_on_source_config_q <= wr_data;                               // [RULE_14]
        end
      end
      // Clear-faults leaves the latch alone; only turn-on clearing or reset frees it
      if (latch_off_req)
      begin
        latched_q <= 1'b1;
      end
      else if (auto_clear)
      begin
        latched_q <= 1'b0;                                                  // [RULE_02]
      end
      output_on_q <= !latched_q && !latch_off_req &&
                     ((!cfg_pin || en_pin) && (!cfg_sw || op_on));          // [RULE_02]
      status_q  <= status_bits;
      alert_n_q <= (status_bits == 32'h0000_0000);                          // [RULE_07]
      rd_valid_q <= rd_req;
      if (rd_req)
      begin
        if (cmd_code == `PFC_CMD_OPERATION)
        begin
          rd_data_q <= operation_control_q;
        end
        else if (cmd_code == `PFC_CMD_TURN_ON_CFG)
        begin
          rd_data_q <= turn_on_source_config_q;
        end
        else if (cmd_code == `PFC_CMD_WRITE_LOCK)
        begin
          rd_data_q <= write_lock_control_q;
        end
        else if (status_wr || ((cmd_code >= `PFC_CMD_STATUS_FIRST) &&
                 (cmd_code <= `PFC_CMD_STATUS_LAST)))
        begin
          rd_data_q <= status_bits[status_sel*8 +: 8];
        end
        else
        begin
          rd_data_q <= 8'h00;
        end
      end
    end
  end

  // Alert response: shift out own address, drop out on losing a bit
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ara_cnt_q  <= 3'd0;
      ara_sh_q   <= 8'h00;
      ara_lost_q <= 1'b0;
      ara_won_q  <= 1'b0;
      sda_out_q  <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end
    else if (ara_req && !alert_n_q)
    begin
      // Answer address plus trailing one bit, msb first
      ara_sh_q   <= {OWN_ADDR, 1'b1};                                       // [RULE_09]
      ara_cnt_q  <= 3'd0;
      ara_lost_q <= 1'b0;
      ara_won_q  <= 1'b0;
      sda_out_q  <= OWN_ADDR[6];
      sda_oe_n_q <= OWN_ADDR[6];
    end
    else if (ara_bit_strobe && !ara_lost_q && (ara_sh_q != 8'h00))
    begin
      // Open drain: a released one seeing zero has lost to a lower address
      if (ara_sh_q[7] && !sda_in)
      begin
        ara_lost_q <= 1'b1;                                                 // [RULE_10]
        sda_oe_n_q <= 1'b1;
        sda_out_q  <= 1'b1;
        ara_sh_q   <= 8'h00;
      end
      else if (ara_cnt_q == 3'd6)
      begin
        ara_won_q  <= 1'b1;                                                 // [RULE_10]
        sda_oe_n_q <= 1'b1;
        sda_out_q  <= 1'b1;
        ara_sh_q   <= 8'h00;
      end
      else
      begin
        ara_sh_q   <= {ara_sh_q[6:0], 1'b0};
        ara_cnt_q  <= ara_cnt_q + 3'd1;
        sda_out_q  <= ara_sh_q[6];
        sda_oe_n_q <= ara_sh_q[6];
      end
    end
    else if (cmd_valid || ara_req)
    begin
      ara_won_q <= 1'b0;
    end
  end

  // Store-all sequencer
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q         <= ST_IDLE;
      wait_cnt_q   <= 32'd0;
      nvm_wr_q     <= 1'b0;
      nvm_idx_q    <= 2'd0;
      nvm_data_q   <= 8'h00;
      store_busy_q <= 1'b0;
    end
    else
    begin
      nvm_wr_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          if (cmd_valid && cmd_code == `PFC_CMD_STORE_ALL)
          begin
            st_q         <= ST_COPY;                                        // [RULE_11]
            nvm_idx_q    <= 2'd3;
            store_busy_q <= 1'b1;
          end
        end
        ST_COPY:
        begin
          // Index and data move together; only the three user registers have stored copies
          nvm_wr_q  <= 1'b1;                                                // [RULE_12]
          nvm_idx_q <= nvm_idx_q + 2'd1;
          if (nvm_idx_q == 2'd3)
          begin
            nvm_data_q <= operation_control_q;
          end
          else if (nvm_idx_q == 2'd0)
          begin
            nvm_data_q <= turn_on_source_config_q;
          end
          else
          begin
            nvm_data_q <= write_lock_control_q;
          end
          if (nvm_idx_q == 2'd1)
          begin
            st_q       <= ST_WAIT;
            wait_cnt_q <= STORE_CNT;
          end
        end
        ST_WAIT:
        begin
          if (wait_cnt_q <= 32'd1)
          begin
            st_q         <= ST_IDLE;                                        // [RULE_13]
            store_busy_q <= 1'b0;
          end
          else
          begin
            wait_cnt_q <= wait_cnt_q - 32'd1;
          end
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // pfc_fault_clear

// ==== bench/pfc_host_model.sv ====
/*
  Host model: issues command, write, read and alert-response traffic.
  Assumes the design samples its inputs on the rising edge of mclk.
*/
`timescale 1ns/1ps
module pfc_host_model
(
  // Clock
  input  wire       mclk,
  // Transactions
  output reg        cmd_valid,
  output reg  [7:0] cmd_code,
  output reg        wr_valid,
  output reg  [7:0] wr_data,
  output reg        rd_req,
  input  wire [7:0] rd_data_q,
  // Alert response
  output reg        ara_req,
  output reg        ara_bit_strobe,
  output wire       sda_in,
  input  wire       sda_oe_n_q
);
  reg rival_q;
  integer k;
  initial {cmd_valid, cmd_code, wr_valid, wr_data, rd_req, ara_req, ara_bit_strobe} = 0;
  initial rival_q = 1'b1;
  // Pulled-up wired line: low if either party pulls it
  assign sda_in = sda_oe_n_q & rival_q;
  task cyc;
    @(posedge mclk) #1;
  endtask
  task send(input [7:0] c);
    cyc;
    cmd_code = c;
    cmd_valid = 1;
    cyc;
    cmd_valid = 0;
  endtask
  task wr(input [7:0] c, input [7:0] d);
    send(c);
    wr_data = d;
    wr_valid = 1;
    cyc;
    wr_valid = 0;
  endtask
  task rd(input [7:0] c, output [7:0] d);
    cyc;
    cmd_code = c;
    rd_req = 1;
    cyc;
    rd_req = 0;
    d = rd_data_q;
  endtask
  // Rival address takes part bit by bit, most significant first
  task ara(input [6:0] rival);
    cyc;
    ara_req = 1;
    cyc;
    ara_req = 0;
    for (k = 6; k >= 0; k = k - 1)
    begin
      rival_q = rival[k];
      cyc;
      ara_bit_strobe = 1;
      cyc;
      ara_bit_strobe = 0;
    end
    rival_q = 1'b1;
  endtask
endmodule // pfc_host_model

// ==== bench/pfc_fault_clear_sva.sv ====
/*
  Checker for the fault-clear block, bound to its top ports.
  Assumes a single mclk domain and resetn as its reset.
*/
`timescale 1ns/1ps
`include "pfc_defines.vh"
module pfc_fault_clear_sva
#(
  parameter       STORE_CYCLES = 20,
  parameter [6:0] OWN_ADDR     = 7'h40
)
(
  input logic        mclk,
  input logic        resetn,
  input logic        cmd_valid,
  input logic [7:0]  cmd_code,
  input logic        rd_req,
  input logic        rd_valid_q,
  input logic        ara_req,
  input logic        ara_bit_strobe,
  input logic        sda_in,
  input logic        sda_oe_n_q,
  input logic        ara_won_q,
  input logic [31:0] fault_cond,
  input logic        output_on_q,
  input logic        alert_n_q,
  input logic [31:0] status_q,
  input logic        nvm_wr_q,
  input logic [1:0]  nvm_idx_q,
  input logic        store_busy_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire clr = cmd_valid && cmd_code == `PFC_CMD_CLEAR_FAULTS;
  wire sto = cmd_valid && cmd_code == `PFC_CMD_STORE_ALL && !store_busy_q;
  reg [31:0] busy_cnt_q;
  // Counts the busy window so its length is checked without long repetitions
  always @(posedge mclk or negedge resetn)
    if (!resetn) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= store_busy_q ? busy_cnt_q + 1 : 32'h0;
  // Status output is a registered copy of the bits, so a clear shows two edges on
  clear_all_a: assert property (clr && fault_cond == 0 |-> ##2 status_q == 0)
    else $error("status not cleared by clear command");
  alert_lag_a: assert property (1 |=> alert_n_q == (status_q == 32'h0))
    else $error("alert does not follow status");
  stay_off_a: assert property (clr && !output_on_q |=> !output_on_q)
    else $error("clear command restarted output");
  fault_set_a: assert property (fault_cond != 0 |-> ##2
    (status_q & $past(fault_cond, 2)) == $past(fault_cond, 2))
    else $error("live fault not recorded");
  read_ans_a: assert property (1 |=> rd_valid_q == $past(rd_req))
    else $error("read answer latency wrong");
  store_seq_a: assert property (sto |-> ##2 nvm_wr_q && nvm_idx_q == 2'd0
    ##1 nvm_wr_q && nvm_idx_q == 2'd1 ##1 nvm_wr_q && nvm_idx_q == 2'd2)
    else $error("store copy sequence wrong");
  busy_len_a: assert property ($fell(store_busy_q) |->
    $past(busy_cnt_q) >= STORE_CYCLES && $past(busy_cnt_q) <= STORE_CYCLES + 8)
    else $error("store busy window length wrong");
  ara_lost_a: assert property (ara_bit_strobe && sda_oe_n_q && !sda_in |=>
    (sda_oe_n_q && !ara_won_q) [*4])
    else $error("lost arbitration but kept going");
  won_clear_a: assert property (ara_won_q && (cmd_valid || ara_req) |=> !ara_won_q)
    else $error("won flag not cleared");
endmodule // pfc_fault_clear_sva
bind pfc_fault_clear pfc_fault_clear_sva #(.STORE_CYCLES(STORE_CYCLES), .OWN_ADDR(OWN_ADDR))
  u_pfc_fault_clear_sva (.*);

// ==== bench/pfc_fault_clear_tb.sv ====
/*
  Testbench: register, fault clearing, turn-on modes, store and alert response.
  Assumes the host model drives all transaction inputs.
*/
`timescale 1ns/1ps
`include "pfc_defines.vh"
module pfc_fault_clear_tb;
  reg         mclk = 0, resetn = 0, en_pin = 1, latch_off_req = 0;
  reg  [31:0] fault_cond = 0;
  reg  [7:0]  d, cfgv, exp_d[0:2];
  wire        cmd_valid, wr_valid, rd_req, rd_valid_q, ara_req, ara_bit_strobe, sda_in;
  wire [7:0]  cmd_code, wr_data, rd_data_q, nvm_data_q;
  wire        sda_out_q, sda_oe_n_q, ara_won_q, output_on_q, alert_n_q, nvm_wr_q, store_busy_q;
  wire [1:0]  nvm_idx_q;
  wire [31:0] status_q;
  integer     bad_count = 0, checks = 0, i, m, n;
  always #5 mclk = ~mclk;
  // Short busy window keeps the run brief
  pfc_fault_clear #(.STORE_CYCLES(20)) u_pfc_fault_clear (.*);
  pfc_host_model u_pfc_host_model (.*);
  task cyc;
    @(posedge mclk) #1;
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task rdc(input [7:0] c, input [7:0] e);
    u_pfc_host_model.rd(c, d);
    chk("read", {24'h0, d}, {24'h0, e});
  endtask
  task fault(input [31:0] f);
    cyc;
    fault_cond = f;
    cyc;
    fault_cond = 0;
  endtask
  task print_verdict;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1 resetn = 1;
    rdc(`PFC_CMD_OPERATION, `PFC_OPERATION_RST);
    rdc(`PFC_CMD_TURN_ON_CFG, `PFC_TURN_ON_CFG_RST);
    rdc(`PFC_CMD_WRITE_LOCK, `PFC_WRITE_LOCK_RST);
    rdc(8'h55, 8'h00);
    u_pfc_host_model.wr(`PFC_CMD_WRITE_LOCK, 8'h01);
    u_pfc_host_model.wr(`PFC_CMD_OPERATION, 8'h00);
    rdc(`PFC_CMD_OPERATION, 8'h80);
    u_pfc_host_model.wr(`PFC_CMD_WRITE_LOCK, 8'h00);
    fault(32'h0000_0201);
    cyc;
    chk("alert", alert_n_q, 0);
    u_pfc_host_model.wr(8'h7a, 8'h01);
    // The status output trails the status bits by one edge
    cyc;
    chk("status", status_q, 32'h200);
    u_pfc_host_model.send(`PFC_CMD_CLEAR_FAULTS);
    cyc;
    chk("status", status_q, 0);
    chk("alert", alert_n_q, 1);
    fault_cond = 32'h0001_0000;
    u_pfc_host_model.send(`PFC_CMD_CLEAR_FAULTS);
    cyc;
    chk("status", status_q, 32'h0001_0000);
    chk("alert", alert_n_q, 0);
    fault_cond = 0;
    latch_off_req = 1;
    cyc;
    latch_off_req = 0;
    u_pfc_host_model.send(`PFC_CMD_CLEAR_FAULTS);
    repeat (3) cyc;
    chk("output", output_on_q, 0);
    for (m = 0; m < 3; m = m + 1)
    begin
      cfgv = (m == 0) ? 8'h18 : (m == 1) ? 8'h14 : 8'h1c;
      u_pfc_host_model.wr(`PFC_CMD_TURN_ON_CFG, cfgv);
      en_pin = 1;
      u_pfc_host_model.wr(`PFC_CMD_OPERATION, 8'h80);
      fault(32'h4);
      u_pfc_host_model.wr(`PFC_CMD_OPERATION, 8'h00);
      cyc;
      chk("op low", status_q, (m == 1) ? 0 : 32'h4);
      en_pin = 0;
      repeat (2) cyc;
      chk("pin low", status_q, 0);
    end
    u_pfc_host_model.wr(`PFC_CMD_OPERATION, 8'h80);
    exp_d[0] = 8'h80;
    exp_d[1] = 8'h1c;
    exp_d[2] = 8'h00;
    u_pfc_host_model.send(`PFC_CMD_STORE_ALL);
    n = 0;
    for (i = 0; i < 10; i = i + 1)
    begin
      if (nvm_wr_q === 1'b1)
      begin
        chk("nvm idx", nvm_idx_q, n);
        chk("nvm data", nvm_data_q, exp_d[n % 3]);
        n = n + 1;
      end
      cyc;
    end
    chk("nvm count", n, 3);
    // The host holds off further stores until the busy window ends
    for (i = 0; i < 100 && store_busy_q !== 1'b0; i = i + 1) cyc;
    chk("busy", store_busy_q, 0);
    fault(32'h1);
    for (m = 0; m < 3; m = m + 1)
    begin
      u_pfc_host_model.ara((m == 0) ? 7'h7f : (m == 1) ? 7'h41 : 7'h20);
      cyc;
      chk("ara won", ara_won_q, (m < 2) ? 1 : 0);
      chk("sda release", sda_out_q, 1);
    end
    u_pfc_host_model.wr(`PFC_CMD_OPERATION, 8'h00);
    // A fault stands when bias drops, so the reset has something to clear
    fault(32'h8);
    resetn = 0;
    cyc;
    resetn = 1;
    cyc;
    chk("status", status_q, 0);
    chk("alert", alert_n_q, 1);
    rdc(`PFC_CMD_OPERATION, `PFC_OPERATION_RST);
    print_verdict;
  end
endmodule // pfc_fault_clear_tb
